// file: rtl/bwc_decode.sv
// Combinational forwarding decode from the bridge window settings.
// Assumes the caller registers the results; no state is held here.
`timescale 1ns/10ps
module bwc_decode
    import bwc_pkg::*;
(
    input  wire logic [63:0] i_pf_base,
    input  wire logic [63:0] i_pf_limit,
    input  wire logic [31:0] i_io_base,
    input  wire logic [31:0] i_io_limit,
    input  wire logic [4:0]  i_brg,
    input  wire logic [63:0] i_mem_addr,
    input  wire logic [31:0] i_io_addr,
    output wire logic        o_mem_dn,
    output wire logic        o_io_dn,
    output wire logic        o_io_up
);

    // ------------------------------------------------------------
    // Window and VGA matches
    // ------------------------------------------------------------
    wire logic mem_in_win;
    wire logic vga_mem;
    wire logic io_in_win;
    wire logic io_low64k;
    wire logic isa_alias;
    wire logic vga_lo10;
    wire logic vga_io;

    // Prefetchable window, inclusive at both ends
    assign mem_in_win = (i_mem_addr >= i_pf_base) && (i_mem_addr <= i_pf_limit);
    // Fixed VGA frame buffer range
    assign vga_mem    = (i_mem_addr >= VGA_MEM_LO) && (i_mem_addr <= VGA_MEM_HI);
    // I/O window, limit low bits read as ones
    assign io_in_win  = (i_io_addr >= i_io_base) && (i_io_addr <= i_io_limit);
    assign io_low64k  = (i_io_addr[31:16] == 16'h0000);
    // Top 768 bytes of each 1KB block below 64KB are ISA aliases
    assign isa_alias  = io_low64k && (i_io_addr[9:8] != 2'b00);
    // Ten-bit VGA port ranges
    assign vga_lo10   = ((i_io_addr[9:0] >= VGA_IO_A_LO) && (i_io_addr[9:0] <= VGA_IO_A_HI))
                     || ((i_io_addr[9:0] >= VGA_IO_B_LO) && (i_io_addr[9:0] <= VGA_IO_B_HI));
    // Width 0 ignores upper bits; width 1 also needs bits 31:10 clear
    assign vga_io     = vga_lo10 && (!i_brg[BIT_VGA16]
                     || (io_low64k && (i_io_addr[15:10] == 6'h00)));

    // ------------------------------------------------------------
    // Routing results
    // ------------------------------------------------------------
    // VGA ranges claimed only while enabled
    assign o_mem_dn = mem_in_win || (i_brg[BIT_VGA] && vga_mem);
    // ISA mode sends aliases upstream instead of down
    assign o_io_up  = io_in_win && i_brg[BIT_ISA] && isa_alias
                   && !(i_brg[BIT_VGA] && vga_io);
    assign o_io_dn  = (io_in_win && !o_io_up) || (i_brg[BIT_VGA] && vga_io);

endmodule

// file: rtl/bwc_pkg.sv
// Constants shared by the bridge window register bank.
// Assumes a single 32-bit APB register port and byte addresses.
package bwc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PF_BASE_HI  = 8'h28;
    localparam logic [7:0] OFS_PF_LIMIT_HI = 8'h2C;
    localparam logic [7:0] OFS_IO_HI       = 8'h30;
    localparam logic [7:0] OFS_CAP_PTR     = 8'h34;
    localparam logic [7:0] OFS_INT_BRG     = 8'h3C;
    localparam logic [7:0] OFS_EVT_STAT    = 8'h80;
    localparam logic [7:0] OFS_EVT_MASK    = 8'h84;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          POS_PIN         = 8;
    localparam int          POS_BRG         = 16;
    localparam int          POS_IO_LIMIT    = 16;
    localparam int          BRG_W           = 5;
    localparam int          BIT_PAR_RESP    = 0;
    localparam int          BIT_SECONDARY_ERROR_FORWARD_ENABLE = 1;
    localparam int          BIT_ISA         = 2;
    localparam int          BIT_VGA         = 3;
    localparam int          BIT_VGA16       = 4;
    localparam logic [31:0] RST_PF_HI       = 32'h0000_0000;
    localparam logic [15:0] RST_IO_HI       = 16'h0000;
    localparam logic [7:0]  RST_INT_LINE    = 8'h00;
    localparam logic [7:0]  RST_INT_PIN     = 8'h00;
    localparam logic [4:0]  RST_BRG         = 5'h00;
    localparam logic [7:0]  VAL_CAP_PTR     = 8'h40;

    // ------------------------------------------------------------
    // Event status bits
    // ------------------------------------------------------------
    localparam int          EVT_W           = 3;
    localparam int          EVT_POISON      = 0;
    localparam int          EVT_ERR_DROP    = 1;
    localparam int          EVT_HOTPLUG     = 2;

    // ------------------------------------------------------------
    // Address decode constants
    // ------------------------------------------------------------
    localparam logic [19:0] PF_LIMIT_ONES   = 20'hFFFFF;
    localparam logic [11:0] IO_LIMIT_ONES   = 12'hFFF;
    localparam logic [63:0] VGA_MEM_LO      = 64'h0000_0000_000A_0000;
    localparam logic [63:0] VGA_MEM_HI      = 64'h0000_0000_000B_FFFF;
    localparam logic [9:0]  VGA_IO_A_LO     = 10'h3B0;
    localparam logic [9:0]  VGA_IO_A_HI     = 10'h3BB;
    localparam logic [9:0]  VGA_IO_B_LO     = 10'h3C0;
    localparam logic [9:0]  VGA_IO_B_HI     = 10'h3DF;

endpackage

// file: rtl/bwc_regs.sv
// Bridge window configuration registers for one switch port.
// Assumes APB3 register access, one 250 MHz clock and synchronous
// forwarding-logic inputs; lower base/limit fields come from outside.
`timescale 1ns/10ps

// Operation
// - Writable 32-bit prefetch limit upper half, reset zero, used in forwarding.
// - Writable 16-bit I/O base upper half, reset zero, used in forwarding.
// - Writable 16-bit I/O limit upper half in bits 31:16, reset zero.
// - Capability pointer reads as fixed 40h.
// - Writable interrupt line byte at 3Ch, no hardware effect, reset zero.
// - Read-only interrupt pin byte, reset 00h; hot-plug raises INTA message.
// - Downstream port pin value may be loaded from sideband or EEPROM.
// - Bit 16 off ignores poisoned TLPs; on detects and reports them.
// - Bit 17 gates forwarding of secondary error messages upstream.
// - Bit 18 sends ISA alias I/O addresses in window upstream.
// - Bit 19 forwards VGA memory and I/O ranges, else ignores them.
// - VGA I/O means low ten bits in 3B0h-3BBh or 3C0h-3DFh.
// - VGA decode width 0 matches on ten address bits only.
// - Bit 20 set matches VGA I/O on all 32 address bits, bits 31:10 clear.
// - Prefetch limit low twenty address bits taken as all ones.
// - Writable prefetch base upper half at 28h joins lower base.
module bwc_regs
    import bwc_pkg::*;
#(
    parameter bit IS_DOWNSTREAM = 1'b1
)(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_pready,
    output logic [31:0]      o_prdata,
    output logic             o_pslverr,
    // Lower window fields held elsewhere
    input  wire logic [11:0] i_pf_base_lo,
    input  wire logic [11:0] i_pf_limit_lo,
    input  wire logic [3:0]  i_io_base_lo,
    input  wire logic [3:0]  i_io_limit_lo,
    // Interrupt pin load from sideband or EEPROM
    input  wire logic        i_pin_load,
    input  wire logic [7:0]  i_pin_load_val,
    // Secondary-side events
    input  wire logic        i_poison_seen,
    input  wire logic        i_err_msg,
    input  wire logic        i_hotplug,
    // Forwarding requests
    input  wire logic        i_mem_vld,
    input  wire logic [63:0] i_mem_addr,
    input  wire logic        i_io_vld,
    input  wire logic [31:0] i_io_addr,
    // Results
    output logic             o_mem_fwd_dn,
    output logic             o_io_fwd_dn,
    output logic             o_io_fwd_up,
    output logic             o_route_vld,
    output logic             o_poison_rpt,
    output logic             o_err_fwd,
    output logic             o_inta_msg,
    output logic             o_irq
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    // Two-stage release so the deassert edge is clean
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0]      pf_base_hi_q;
    logic [31:0]      pf_limit_hi_q;
    logic [15:0]      io_base_hi_q;
    logic [15:0]      io_limit_hi_q;
    logic [7:0]       int_line_q;
    logic [7:0]       int_pin_q;
    logic [BRG_W-1:0] brg_q;
    logic [EVT_W-1:0] stat_q;
    logic [EVT_W-1:0] stat_d;
    logic [EVT_W-1:0] mask_q;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic        access;
    wire logic        wr_en;
    wire logic        sel_pfb;
    wire logic        sel_pfl;
    wire logic        sel_io;
    wire logic        sel_cap;
    wire logic        sel_int;
    wire logic        sel_stat;
    wire logic        sel_mask;
    wire logic        mapped;
    wire logic [31:0] rd_mux;
    logic             pready_q;
    logic [31:0]      prdata_q;
    logic             pslverr_q;

    // One wait state: answer lands on the second access cycle
    assign access   = i_psel && i_penable && !pready_q;
    assign wr_en    = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;
    assign sel_pfb  = (i_paddr == OFS_PF_BASE_HI);
    assign sel_pfl  = (i_paddr == OFS_PF_LIMIT_HI);
    assign sel_io   = (i_paddr == OFS_IO_HI);
    assign sel_cap  = (i_paddr == OFS_CAP_PTR);
    assign sel_int  = (i_paddr == OFS_INT_BRG);
    assign sel_stat = (i_paddr == OFS_EVT_STAT);
    assign sel_mask = (i_paddr == OFS_EVT_MASK);
    assign mapped   = sel_pfb || sel_pfl || sel_io || sel_cap
                   || sel_int || sel_stat || sel_mask;

    // Read mux; bridge bits 21 to 31 read as zero
    assign rd_mux = sel_pfb  ? pf_base_hi_q :
                    sel_pfl  ? pf_limit_hi_q :
                    sel_io   ? {io_limit_hi_q, io_base_hi_q} :
                    sel_cap  ? {24'h000000, VAL_CAP_PTR} :
                    sel_int  ? {11'h000, brg_q, int_pin_q, int_line_q} :
                    sel_stat ? {29'h0000000, stat_q} :
                    sel_mask ? {29'h0000000, mask_q} :
                               32'h0000_0000;

    // Answer registers; unmapped addresses get an error and zero data
    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= access;
            if (access) begin
                prdata_q  <= i_pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_q <= !mapped;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Window registers
    // ------------------------------------------------------------
    // Upper halves written only on the completing edge
    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pf_base_hi_q  <= RST_PF_HI;
            pf_limit_hi_q <= RST_PF_HI;
            io_base_hi_q  <= RST_IO_HI;
            io_limit_hi_q <= RST_IO_HI;
        end else if (wr_en) begin
            if (sel_pfb) begin
                pf_base_hi_q <= i_pwdata;
            end
            if (sel_pfl) begin
                pf_limit_hi_q <= i_pwdata;
            end
            if (sel_io) begin
                io_base_hi_q  <= i_pwdata[15:0];
                io_limit_hi_q <= i_pwdata[POS_IO_LIMIT +: 16];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt line, pin and bridge control
    // ------------------------------------------------------------
    // Line is scratch for software only; nothing here reads it
    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            int_line_q <= RST_INT_LINE;
            brg_q      <= RST_BRG;
        end else if (wr_en && sel_int) begin
            int_line_q <= i_pwdata[7:0];
            brg_q      <= i_pwdata[POS_BRG +: BRG_W];
        end
    end

    // Pin is read-only to software; upstream ports keep the default
    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            int_pin_q <= RST_INT_PIN;
        end else if (IS_DOWNSTREAM && i_pin_load) begin
            int_pin_q <= i_pin_load_val;
        end
    end

    // ------------------------------------------------------------
    // Window assembly
    // ------------------------------------------------------------
    wire logic [63:0] pf_base;
    wire logic [63:0] pf_limit;
    wire logic [31:0] io_base;
    wire logic [31:0] io_limit;
    wire logic        mem_dn;
    wire logic        io_dn;
    wire logic        io_up;

    // Base low bits zero, limit low bits ones
    assign pf_base  = {pf_base_hi_q, i_pf_base_lo, 20'h00000};
    assign pf_limit = {pf_limit_hi_q, i_pf_limit_lo, PF_LIMIT_ONES};
    assign io_base  = {io_base_hi_q, i_io_base_lo, 12'h000};
    assign io_limit = {io_limit_hi_q, i_io_limit_lo, IO_LIMIT_ONES};

    bwc_decode u_decode (
        .i_pf_base  (pf_base),
        .i_pf_limit (pf_limit),
        .i_io_base  (io_base),
        .i_io_limit (io_limit),
        .i_brg      (brg_q),
        .i_mem_addr (i_mem_addr),
        .i_io_addr  (i_io_addr),
        .o_mem_dn   (mem_dn),
        .o_io_dn    (io_dn),
        .o_io_up    (io_up)
    );

    // ------------------------------------------------------------
    // Routing outputs
    // ------------------------------------------------------------
    // Registered so the forwarding path sees a clean one-cycle answer
    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_mem_fwd_dn <= 1'b0;
            o_io_fwd_dn  <= 1'b0;
            o_io_fwd_up  <= 1'b0;
            o_route_vld  <= 1'b0;
        end else begin
            o_mem_fwd_dn <= i_mem_vld && mem_dn;
            o_io_fwd_dn  <= i_io_vld && io_dn;
            o_io_fwd_up  <= i_io_vld && io_up;
            o_route_vld  <= i_mem_vld || i_io_vld;
        end
    end

    // ------------------------------------------------------------
    // Error, poison and hot-plug handling
    // ------------------------------------------------------------
    wire logic poison_hit;
    wire logic err_drop;

    // Poison ignored entirely while reporting is off
    assign poison_hit = i_poison_seen && brg_q[BIT_PAR_RESP];
    // A blocked error message is noted so software can see the loss
    assign err_drop   = i_err_msg && !brg_q[BIT_SECONDARY_ERROR_FORWARD_ENABLE];

    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_poison_rpt <= 1'b0;
            o_err_fwd    <= 1'b0;
            o_inta_msg   <= 1'b0;
        end else begin
            o_poison_rpt <= poison_hit;
            o_err_fwd    <= i_err_msg && brg_q[BIT_SECONDARY_ERROR_FORWARD_ENABLE];
            o_inta_msg   <= i_hotplug;
        end
    end

    // ------------------------------------------------------------
    // Event status and interrupt
    // ------------------------------------------------------------
    wire logic [EVT_W-1:0] evt_set;
    wire logic [EVT_W-1:0] evt_clr;

    assign evt_set = {i_hotplug, err_drop, poison_hit};
    assign evt_clr = (wr_en && sel_stat) ? i_pwdata[EVT_W-1:0] : '0;

    // Write one clears; a new event in the same cycle wins
    always_comb begin
        stat_d = (stat_q & ~evt_clr) | evt_set;
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stat_q <= '0;
            mask_q <= '0;
            o_irq  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            if (wr_en && sel_mask) begin
                mask_q <= i_pwdata[EVT_W-1:0];
            end
            // Follows the stored status one cycle later
            o_irq  <= |(stat_q & mask_q);
        end
    end

    // ------------------------------------------------------------
    // Bus outputs
    // ------------------------------------------------------------
    assign o_pready  = pready_q;
    assign o_prdata  = prdata_q;
    assign o_pslverr = pslverr_q;

endmodule

// file: verif/bwc_host.sv
// Upstream host model issuing APB configuration reads and writes.
// Assumes one clock; the bench calls xfer, one transfer at a time.
`timescale 1ns/10ps
module bwc_host (
    input  wire logic        i_clk_sys,
    input  wire logic        i_pready,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pslverr,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [7:0]       o_paddr,
    output logic [31:0]      o_pwdata
);
    // Bus idle from time zero
    initial begin
        {o_psel, o_penable, o_pwrite} = 3'h0;
        o_paddr = 8'h00;
        o_pwdata = 32'h0;
    end
    // Request held until ready is sampled; only the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge i_clk_sys);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clk_sys);
        o_penable <= 1'b1;
        do @(posedge i_clk_sys); while (i_pready !== 1'b1);
        r = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
    endtask
endmodule

// file: verif/bwc_props.sv
// Port checker for the bridge window register bank.
// Assumes a bind to bwc_regs; it shadows bridge and mask writes itself.
`timescale 1ns/10ps
module bwc_props
    import bwc_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_rstn,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic [31:0] o_prdata,
    input wire logic        i_poison_seen,
    input wire logic        i_err_msg,
    input wire logic        i_hotplug,
    input wire logic        i_mem_vld,
    input wire logic [63:0] i_mem_addr,
    input wire logic        o_mem_fwd_dn,
    input wire logic        o_io_fwd_dn,
    input wire logic        o_io_fwd_up,
    input wire logic        o_poison_rpt,
    input wire logic        o_err_fwd,
    input wire logic        o_inta_msg,
    input wire logic        o_irq
);
    logic [4:0] brg_q;
    logic [2:0] mask_q;
    // Shadows track completed writes only
    wire logic acc     = i_psel & i_penable & ~o_pready;
    wire logic wr_done = i_psel & i_penable & o_pready & i_pwrite;
    wire logic mapped  = (i_paddr == OFS_PF_BASE_HI) | (i_paddr == OFS_PF_LIMIT_HI)
                       | (i_paddr == OFS_IO_HI) | (i_paddr == OFS_CAP_PTR)
                       | (i_paddr == OFS_INT_BRG) | (i_paddr == OFS_EVT_STAT)
                       | (i_paddr == OFS_EVT_MASK);
    wire logic par_en  = brg_q[BIT_PAR_RESP];
    wire logic fwd_en  = brg_q[BIT_SECONDARY_ERROR_FORWARD_ENABLE];
    wire logic in_vga  = brg_q[BIT_VGA] & (i_mem_addr >= VGA_MEM_LO)
                       & (i_mem_addr <= VGA_MEM_HI);
    // Shadow copies of the bridge bits and the event mask
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            brg_q  <= RST_BRG;
            mask_q <= 3'h0;
        end else if (wr_done && i_paddr == OFS_INT_BRG) begin
            brg_q <= i_pwdata[POS_BRG +: BRG_W];
        end else if (wr_done && i_paddr == OFS_EVT_MASK) begin
            mask_q <= i_pwdata[EVT_W-1:0];
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    sequence s_answer;
        o_pready ##1 !o_pready;
    endsequence
    a_apb_one_wait: assert property (acc |=> s_answer)
        else $error("ready not one cycle after access start");
    a_unmapped_err: assert property (acc && !mapped |=> o_pslverr)
        else $error("no slave error on unmapped address");
    a_cap_value: assert property (acc && !i_pwrite && i_paddr == OFS_CAP_PTR
        |=> o_prdata[7:0] == VAL_CAP_PTR) else $error("capability pointer wrong");
    a_poison_gate: assert property (i_poison_seen |=> o_poison_rpt == $past(par_en))
        else $error("poison report not gated by bridge bit");
    a_err_gate: assert property (i_err_msg |=> o_err_fwd == $past(fwd_en))
        else $error("error forward not gated by bridge bit");
    a_inta_pulse: assert property (i_hotplug |=> o_inta_msg ##1 !o_inta_msg)
        else $error("hot-plug message pulse wrong");
    a_irq_raise: assert property (i_hotplug && mask_q[EVT_HOTPLUG] |-> ##2 o_irq)
        else $error("interrupt not raised by unmasked event");
    a_io_one_way: assert property (o_io_fwd_dn |-> !o_io_fwd_up)
        else $error("I/O routed both ways");
    a_vga_mem: assert property (i_mem_vld && in_vga |=> o_mem_fwd_dn)
        else $error("VGA memory access not forwarded");
endmodule
bind bwc_regs bwc_props bwc_props_i (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_prdata(o_prdata), .i_poison_seen(i_poison_seen),
    .i_err_msg(i_err_msg), .i_hotplug(i_hotplug), .i_mem_vld(i_mem_vld),
    .i_mem_addr(i_mem_addr), .o_mem_fwd_dn(o_mem_fwd_dn), .o_io_fwd_dn(o_io_fwd_dn),
    .o_io_fwd_up(o_io_fwd_up), .o_poison_rpt(o_poison_rpt), .o_err_fwd(o_err_fwd),
    .o_inta_msg(o_inta_msg), .o_irq(o_irq)
);

// file: verif/tb_top.sv
// Self-checking bench for the bridge window register bank.
// Assumes bwc_host owns the APB pins; every other input is driven here.
`timescale 1ns/10ps
module tb_top
    import bwc_pkg::*;
;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        pld = 1'b0, pois = 1'b0, errm = 1'b0, hp = 1'b0, mv = 1'b0, iv = 1'b0;
    logic [7:0]  pldv = 8'h00;
    logic [11:0] pfb = 12'h000, pfl = 12'h001;
    logic [3:0]  iob = 4'h0, iol = 4'hF;
    logic [63:0] ma = 64'h0;
    logic [31:0] ia = 32'h0;
    wire logic        psel, pen, pwr, pready, pslverr, mdn, idn, iup, rv, prpt, efwd, inta, irq;
    wire logic [7:0]  paddr;
    wire logic [31:0] pwdata, prdata;
    int          n_fail = 0, tests_run = 0;
    always #2 clk = ~clk;
    bwc_host host_i (.i_clk_sys(clk), .i_pready(pready), .i_prdata(prdata),
        .i_pslverr(pslverr), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
        .o_paddr(paddr), .o_pwdata(pwdata));
    bwc_regs bwc_regs_i (.i_clk_sys(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_pf_base_lo(pfb), .i_pf_limit_lo(pfl),
        .i_io_base_lo(iob), .i_io_limit_lo(iol), .i_pin_load(pld), .i_pin_load_val(pldv),
        .i_poison_seen(pois), .i_err_msg(errm), .i_hotplug(hp), .i_mem_vld(mv),
        .i_mem_addr(ma), .i_io_vld(iv), .i_io_addr(ia), .o_mem_fwd_dn(mdn),
        .o_io_fwd_dn(idn), .o_io_fwd_up(iup), .o_route_vld(rv), .o_poison_rpt(prpt),
        .o_err_fwd(efwd), .o_inta_msg(inta), .o_irq(irq));
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t word %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        logic        s;
        host_i.xfer(1'b0, a, 32'h0, r, s);
        chk32(r, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        s;
        host_i.xfer(1'b1, a, d, r, s);
    endtask
    // One-cycle event pulse; returns once the answer settles
    task automatic ev(input int k);
        @(posedge clk);
        {pois, errm, hp} <= {k == 0, k == 1, k == 2};
        @(posedge clk);
        {pois, errm, hp} <= 3'h0;
        #1;
    endtask
    task automatic qio(input logic [31:0] a, input logic dn, input logic up);
        @(posedge clk);
        {iv, ia} <= {1'b1, a};
        @(posedge clk);
        iv <= 1'b0;
        #1;
        chk1(idn, dn);
        chk1(iup, up);
        chk1(rv, 1'b1);
    endtask
    task automatic qmem(input logic [63:0] a, input logic dn);
        @(posedge clk);
        {mv, ma} <= {1'b1, a};
        @(posedge clk);
        mv <= 1'b0;
        #1;
        chk1(mdn, dn);
    endtask
    task automatic t_regs;
        logic [31:0] r;
        logic        s;
        rd(OFS_PF_LIMIT_HI, 32'h0);
        rd(OFS_IO_HI, 32'h0);
        rd(OFS_INT_BRG, 32'h0);
        wr(OFS_PF_LIMIT_HI, 32'hA5A5_5A5A);
        rd(OFS_PF_LIMIT_HI, 32'hA5A5_5A5A);
        wr(OFS_IO_HI, 32'h1234_5678);
        rd(OFS_IO_HI, 32'h1234_5678);
        wr(OFS_CAP_PTR, 32'h0);
        rd(OFS_CAP_PTR, 32'h0000_0040);
        wr(OFS_INT_BRG, 32'hFFFF_FFFF);
        rd(OFS_INT_BRG, 32'h001F_00FF);
        host_i.xfer(1'b0, 8'h50, 32'h0, r, s);
        chk1(s, 1'b1);
        @(posedge clk);
        {pld, pldv} <= {1'b1, 8'h01};
        @(posedge clk);
        pld <= 1'b0;
        rd(OFS_INT_BRG, 32'h001F_01FF);
        wr(OFS_INT_BRG, 32'h0);
    endtask
    // Reported poison and a blocked error leave sticky status; only the hot-plug bit is unmasked
    task automatic t_events;
        ev(0);
        chk1(prpt, 1'b0);
        ev(1);
        chk1(efwd, 1'b0);
        wr(OFS_INT_BRG, 32'h0003_0000);
        ev(0);
        chk1(prpt, 1'b1);
        ev(1);
        chk1(efwd, 1'b1);
        rd(OFS_EVT_STAT, 32'h3);
        chk1(irq, 1'b0);
        wr(OFS_EVT_MASK, 32'h4);
        ev(2);
        chk1(inta, 1'b1);
        @(posedge clk);
        #1;
        chk1(irq, 1'b1);
        wr(OFS_EVT_STAT, 32'h7);
        rd(OFS_EVT_STAT, 32'h0);
        chk1(irq, 1'b0);
    endtask
    task automatic t_route;
        wr(OFS_PF_BASE_HI, 32'h1);
        wr(OFS_PF_LIMIT_HI, 32'h1);
        wr(OFS_IO_HI, 32'h0);
        wr(OFS_INT_BRG, 32'h0);
        qmem(64'h1_001F_FFFF, 1'b1);
        qmem(64'h1_0020_0000, 1'b0);
        qmem(64'h1_0000_0000, 1'b1);
        qmem(64'h0_FFFF_FFFF, 1'b0);
        @(posedge clk) pfb <= 12'h001;
        qmem(64'h1_000F_FFFF, 1'b0);
        qio(32'h0100, 1'b1, 1'b0);
        wr(OFS_INT_BRG, 32'h0004_0000);
        qio(32'h0100, 1'b0, 1'b1);
        qio(32'h0050, 1'b1, 1'b0);
        wr(OFS_IO_HI, 32'h0001_0001);
        qio(32'h1_0100, 1'b1, 1'b0);
        qio(32'h2_0000, 1'b0, 1'b0);
        wr(OFS_INT_BRG, 32'h0);
        qio(32'h03C0, 1'b0, 1'b0);
        qmem(64'h000A_0000, 1'b0);
        wr(OFS_INT_BRG, 32'h0008_0000);
        qmem(64'h000B_FFFF, 1'b1);
        qmem(64'h000C_0000, 1'b0);
        qio(32'h03BB, 1'b1, 1'b0);
        qio(32'h03BC, 1'b0, 1'b0);
        qio(32'h07C0, 1'b1, 1'b0);
        wr(OFS_INT_BRG, 32'h0018_0000);
        qio(32'h07C0, 1'b0, 1'b0);
        qio(32'h03DF, 1'b1, 1'b0);
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Main sequence; reset held ten cycles, then the synchroniser settles
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_events();
        t_route();
        complete_run();
    end
    // Watchdog, more than thirty times the run length
    initial begin
        repeat (6000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule
